// ---- verilog/dma_channel_pkg.sv ----
/*
  Shared constants and types for one DMA channel control block: register
  indices, control word field positions, reset values and the memory request
  carrier. Assumes a 100 MHz single clock system and a 16-bit register view.
*/
package dma_channel_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] SRC_LOW_IDX   = 32'h50003630;
  localparam logic [31:0] SRC_HIGH_IDX  = 32'h50003632;
  localparam logic [31:0] DST_LOW_IDX   = 32'h50003634;
  localparam logic [31:0] DST_HIGH_IDX  = 32'h50003636;
  localparam logic [31:0] THRESH_IDX    = 32'h50003638;
  localparam logic [31:0] LEN_IDX       = 32'h5000363A;
  localparam logic [31:0] CTRL_IDX      = 32'h5000363C;
  localparam logic [31:0] PROGRESS_IDX  = 32'h5000363E;
  localparam logic [31:0] STATUS_IDX    = 32'h50003640;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE    = 0;
  localparam int CTRL_WIDTH_LO  = 1;
  localparam int CTRL_IRQ_EN    = 3;
  localparam int CTRL_REQ_TRIG  = 4;
  localparam int CTRL_DST_INC   = 5;
  localparam int CTRL_SRC_INC   = 6;
  localparam int CTRL_CIRCULAR  = 7;
  localparam int CTRL_PRIO_LO   = 8;
  localparam int CTRL_IDLE_INS  = 11;
  localparam int CTRL_FILL      = 12;
  localparam int CTRL_EDGE      = 13;
  localparam logic [15:0] CTRL_WMASK = 16'h3FFF;

  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_RST   = 16'h0000;
  localparam logic [15:0] CTRL_RST  = 16'h0000;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [1:0]  size;
    logic [31:0] adr;
    logic [31:0] wdata;
  } mem_req_t;

endpackage

// ---- verilog/channel_priority_arbiter.sv ----
/*
  Fixed priority arbiter across the DMA channels of the engine.
  Assumes requests and priorities come from logic on the same clock.
*/
`timescale 1ns/10ps
module channel_priority_arbiter #(
  parameter int N      = 4,
  parameter int PRIO_W = 3
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic [N-1:0]                 req_i,
  input  wire logic [N-1:0][PRIO_W-1:0]     prio_i,
  output logic      [N-1:0]                 grant_o
);

  // ----------------------------------------------------------------
  // winner selection
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_win
      logic beats;
      always_comb begin
        beats = req_i[gi];
        for (int j = 0; j < N; j++) begin
          if (j != gi && req_i[j]) begin
            // larger value wins, lower channel number wins a tie
            if (prio_i[j] > prio_i[gi]) beats = 1'b0; // RULE8
            if (prio_i[j] == prio_i[gi] && j < gi) beats = 1'b0; // RULE9
          end
        end
      end
      assign grant_o[gi] = beats;
    end
  endgenerate

  a_one_grant: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i != '0) |-> $onehot(grant_o)) // RULE8
    else $error("arbiter must grant exactly one requester");

endmodule // channel_priority_arbiter

// ---- verilog/dma_channel_control.sv ----
/*
  Control logic for one channel of a four channel DMA engine: Wishbone
  register slave, request sensing, arbitration and the item move engine.
  Assumes a memory port on the same clock answering with a one cycle ack,
  and the other channels' requests and priorities on the same clock.
*/
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
// Contract
// RULE1: move length plus one items; zero still moves one item
// RULE2: sense bit clear means level requests, set means rising edge only
// RULE3: fill clear copies item per item; fill set reads once, writes all
// RULE4: a running fill keeps the bus until it is complete
// RULE5: software pairs fill with destination increment and never with requests
// RULE6: idle bit clear gives back-to-back copies holding off lower masters
// RULE7: idle bit set inserts one wait after each store, except request mode; code inserts none in fill mode or after the last store
// RULE8: largest three-bit priority wins; 000 lowest, 111 highest
// RULE9: equal priorities grant the lower numbered channel first
// RULE10: without wraparound stop after the length and clear enable
// RULE11: wraparound in request mode keeps enable, zeroes index, restarts
// RULE12: source advances 1, 2 or 4 bytes per item when incrementing
// RULE13: destination advances 1, 2 or 4 bytes per item when incrementing
// RULE14: request bit clear starts at enable; set waits for peripheral request
// RULE15: interrupt only when its enable bit is set
// RULE16: width field 00 byte, 01 half word, 10 word, 11 reserved
// RULE17: enable clear keeps channel off; setting it activates the channel
// RULE18: read-only progress index counts items and zeroes at completion
// RULE19: addresses formed from start, index, width and increment enables
// RULE20: interrupt when threshold equals index before increment, enabled
// RULE21: each start address is built from low and high 16-bit halves
// RULE22: requests ignored while disabled; arbitration before every bus cycle; code arbitrates once per item, not before writes or fill stores
module dma_channel_control #(
  parameter int ADR_W = 8,
  parameter int CH    = 3
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic [31:0]                       adr_i,
  input  wire logic [31:0]                       dat_i,
  input  wire logic [3:0]                        sel_i,
  input  wire logic                              we_i,
  input  wire logic                              cyc_i,
  input  wire logic                              stb_i,
  output logic      [31:0]                       dat_o,
  output logic                                   ack_o,
  input  wire logic                              dreq_i,
  output logic                                   dack_o,
  input  wire logic [2:0]                        other_req_i,
  input  wire logic [2:0][2:0]                   other_prio_i,
  output logic                                   bus_req_o,
  output logic                                   bus_lock_o,
  output dma_channel_pkg::mem_req_t              mem_o,
  input  wire logic                              mem_ack_i,
  input  wire logic [31:0]                       mem_rdata_i,
  output logic                                   irq_o
);

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_ARB   = 5'b00010,
    S_READ  = 5'b00100,
    S_WRITE = 5'b01000,
    S_GAP   = 5'b10000
  } state_t;

  state_t                      st_r, st_nxt;
  logic [15:0]                 src_lo_r, src_hi_r, dst_lo_r, dst_hi_r;
  logic [15:0]                 thr_r, len_r, ctrl_r, ctrl_nxt, idx_r, idx_nxt;
  logic [31:0]                 data_r;
  logic                        ack_r;
  logic [31:0]                 rdat_r;
  logic                        dreq_s1_r, dreq_s2_r, dreq_d_r, pend_r;
  dma_channel_pkg::mem_req_t   mem_r, mem_nxt;
  logic                        irq_r, dack_r, lock_r, breq_r;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
    hit = (a[ADR_W+1:2] == idx[ADR_W-1:0]);
  endfunction

  function automatic logic [1:0] width_shift(input logic [1:0] w);
    // reserved code moves single bytes so a bad setting never skips memory
    unique case (w)
      dma_channel_pkg::WIDTH_HALF: width_shift = 2'h1; // RULE16
      dma_channel_pkg::WIDTH_WORD: width_shift = 2'h2; // RULE16
      default:                     width_shift = 2'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // control word views
  // ----------------------------------------------------------------
  wire       enable_w   = ctrl_r[dma_channel_pkg::CTRL_ENABLE];
  wire [1:0] width_w    = ctrl_r[dma_channel_pkg::CTRL_WIDTH_LO +: 2];
  wire       irq_en_w   = ctrl_r[dma_channel_pkg::CTRL_IRQ_EN];
  wire       req_trig_w = ctrl_r[dma_channel_pkg::CTRL_REQ_TRIG];
  wire       dinc_w     = ctrl_r[dma_channel_pkg::CTRL_DST_INC];
  wire       sinc_w     = ctrl_r[dma_channel_pkg::CTRL_SRC_INC];
  wire       circ_w     = ctrl_r[dma_channel_pkg::CTRL_CIRCULAR];
  wire [2:0] prio_w     = ctrl_r[dma_channel_pkg::CTRL_PRIO_LO +: 3];
  wire       idle_w     = ctrl_r[dma_channel_pkg::CTRL_IDLE_INS];
  wire       fill_w     = ctrl_r[dma_channel_pkg::CTRL_FILL];
  wire       edge_w     = ctrl_r[dma_channel_pkg::CTRL_EDGE];

  // ----------------------------------------------------------------
  // wishbone slave decode
  // ----------------------------------------------------------------
  wire        acc_w     = cyc_i && stb_i && !ack_r;
  wire        wr_w      = acc_w && we_i;
  wire [15:0] wmask_w   = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  wire        wr_src_lo = wr_w && hit(adr_i, dma_channel_pkg::SRC_LOW_IDX);
  wire        wr_src_hi = wr_w && hit(adr_i, dma_channel_pkg::SRC_HIGH_IDX);
  wire        wr_dst_lo = wr_w && hit(adr_i, dma_channel_pkg::DST_LOW_IDX);
  wire        wr_dst_hi = wr_w && hit(adr_i, dma_channel_pkg::DST_HIGH_IDX);
  wire        wr_thr    = wr_w && hit(adr_i, dma_channel_pkg::THRESH_IDX);
  wire        wr_len    = wr_w && hit(adr_i, dma_channel_pkg::LEN_IDX);
  wire        wr_ctrl   = wr_w && hit(adr_i, dma_channel_pkg::CTRL_IDX);

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] m,
                                        input logic [15:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  wire [15:0] rd_mux =
    hit(adr_i, dma_channel_pkg::SRC_LOW_IDX)  ? src_lo_r :
    hit(adr_i, dma_channel_pkg::SRC_HIGH_IDX) ? src_hi_r :
    hit(adr_i, dma_channel_pkg::DST_LOW_IDX)  ? dst_lo_r :
    hit(adr_i, dma_channel_pkg::DST_HIGH_IDX) ? dst_hi_r :
    hit(adr_i, dma_channel_pkg::THRESH_IDX)   ? thr_r :
    hit(adr_i, dma_channel_pkg::LEN_IDX)      ? len_r :
    hit(adr_i, dma_channel_pkg::CTRL_IDX)     ? ctrl_r :
    hit(adr_i, dma_channel_pkg::PROGRESS_IDX) ? idx_r :
    hit(adr_i, dma_channel_pkg::STATUS_IDX)   ? {11'h000, pend_r, lock_r, breq_r,
                                                 (st_r == S_WRITE), (st_r != S_IDLE)} :
    16'h0000;

  // ----------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------
  wire [31:0] src_start = {src_hi_r, src_lo_r}; // RULE21
  wire [31:0] dst_start = {dst_hi_r, dst_lo_r}; // RULE21
  wire [31:0] step_w    = 32'({16'h0000, idx_r} << width_shift(width_w));
  wire [31:0] src_adr   = src_start + (sinc_w ? step_w : 32'h00000000); // RULE12 RULE19
  wire [31:0] dst_adr   = dst_start + (dinc_w ? step_w : 32'h00000000); // RULE13 RULE19

  // ----------------------------------------------------------------
  // request sensing and arbitration
  // ----------------------------------------------------------------
  wire rise_w    = dreq_s2_r && !dreq_d_r;
  wire level_w   = dreq_s2_r;
  wire have_req  = edge_w ? pend_r : level_w; // RULE2
  wire ready_w   = enable_w && (!req_trig_w || have_req); // RULE14
  wire arb_req   = (st_r == S_ARB) && ready_w;
  wire [3:0]      grant_w;
  wire [3:0][2:0] prio_all = {prio_w, other_prio_i};
  wire            granted  = grant_w[CH];

  channel_priority_arbiter #(
    .N      (4),
    .PRIO_W (3)
  ) channel_priority_arbiter_i (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .req_i   ({arb_req, other_req_i}),
    .prio_i  (prio_all),
    .grant_o (grant_w)
  );

  wire issue_w   = arb_req && granted; // RULE22
  wire item_done = (st_r == S_WRITE) && mem_ack_i;
  wire done_w    = item_done && (idx_r == len_r); // RULE1
  wire restart_w = circ_w && req_trig_w; // RULE11
  wire consume_w = issue_w && req_trig_w && edge_w;

  // ----------------------------------------------------------------
  // move engine
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    idx_nxt  = idx_r;
    mem_nxt  = mem_r;
    ctrl_nxt = ctrl_r;
    unique case (st_r)
      S_IDLE: begin
        if (enable_w) st_nxt = S_ARB; // RULE17
      end
      S_ARB: begin
        if (!enable_w) st_nxt = S_IDLE;
        else if (issue_w) begin
          if (fill_w && idx_r != 16'h0000) begin
            st_nxt  = S_WRITE;
            mem_nxt = '{valid: 1'b1, we: 1'b1, size: width_w, adr: dst_adr, wdata: data_r};
          end else begin
            st_nxt  = S_READ;
            mem_nxt = '{valid: 1'b1, we: 1'b0, size: width_w, adr: src_adr, wdata: 32'h0};
          end
        end
      end
      S_READ: begin
        if (mem_ack_i) begin
          st_nxt  = S_WRITE;
          mem_nxt = '{valid: 1'b1, we: 1'b1, size: width_w, adr: dst_adr, wdata: mem_rdata_i};
        end
      end
      S_WRITE: begin
        if (mem_ack_i) begin
          mem_nxt.valid = 1'b0;
          if (idx_r == len_r) begin
            idx_nxt = 16'h0000; // RULE18
            st_nxt  = restart_w ? S_ARB : S_IDLE;
            if (!restart_w) ctrl_nxt[dma_channel_pkg::CTRL_ENABLE] = 1'b0; // RULE10
          end else begin
            idx_nxt = idx_r + 16'h0001; // RULE18
            if (fill_w) begin
              // fill keeps the bus: next store goes out with no arbitration
              st_nxt  = S_WRITE; // RULE4 RULE3
              mem_nxt = '{valid: 1'b1, we: 1'b1, size: width_w,
                          adr: dst_start + (dinc_w ? 32'({16'h0000, idx_nxt}
                               << width_shift(width_w)) : 32'h0), wdata: data_r};
            end else if (idle_w && !req_trig_w) st_nxt = S_GAP; // RULE7
            else st_nxt = S_ARB; // RULE6
          end
        end
      end
      S_GAP: st_nxt = S_ARB; // RULE7
      default: st_nxt = S_IDLE;
    endcase
    // a software write to the control word wins over the automatic clear
    if (wr_ctrl) ctrl_nxt = merge(ctrl_r, wmask_w & dma_channel_pkg::CTRL_WMASK, dat_i[15:0]);
  end

  wire hold_w   = fill_w || !idle_w || req_trig_w; // RULE6 RULE7
  wire lock_nxt = (st_nxt != S_IDLE) && (st_nxt != S_GAP) && hold_w; // RULE4 RULE6
  wire irq_nxt  = item_done && irq_en_w && (thr_r == idx_r); // RULE20 RULE15

  // ----------------------------------------------------------------
  // flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r  <= S_IDLE;
      idx_r <= dma_channel_pkg::REG_RST;
      mem_r <= '0;
    end else begin
      st_r  <= st_nxt;
      idx_r <= idx_nxt;
      mem_r <= mem_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_lo_r <= dma_channel_pkg::REG_RST;
      src_hi_r <= dma_channel_pkg::REG_RST;
      dst_lo_r <= dma_channel_pkg::REG_RST;
      dst_hi_r <= dma_channel_pkg::REG_RST;
      thr_r    <= dma_channel_pkg::REG_RST;
      len_r    <= dma_channel_pkg::REG_RST;
      ctrl_r   <= dma_channel_pkg::CTRL_RST;
    end else begin
      if (wr_src_lo) src_lo_r <= merge(src_lo_r, wmask_w, dat_i[15:0]);
      if (wr_src_hi) src_hi_r <= merge(src_hi_r, wmask_w, dat_i[15:0]);
      if (wr_dst_lo) dst_lo_r <= merge(dst_lo_r, wmask_w, dat_i[15:0]);
      if (wr_dst_hi) dst_hi_r <= merge(dst_hi_r, wmask_w, dat_i[15:0]);
      if (wr_thr)    thr_r    <= merge(thr_r, wmask_w, dat_i[15:0]);
      if (wr_len)    len_r    <= merge(len_r, wmask_w, dat_i[15:0]);
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r  <= acc_w;
      rdat_r <= acc_w ? {16'h0000, rd_mux} : 32'h00000000;
    end
  end

  // fill data is caught from the single source read
  always_ff @(posedge clk_i) begin
    if (rst_i) data_r <= 32'h00000000;
    else if (st_r == S_READ && mem_ack_i) data_r <= mem_rdata_i; // RULE3
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dreq_s1_r <= 1'b0;
      dreq_s2_r <= 1'b0;
      dreq_d_r  <= 1'b0;
      pend_r    <= 1'b0;
    end else begin
      dreq_s1_r <= dreq_i;
      dreq_s2_r <= dreq_s1_r;
      dreq_d_r  <= dreq_s2_r;
      // a new edge in the consume cycle is kept: set wins
      if (!enable_w) pend_r <= 1'b0; // RULE22
      else if (rise_w) pend_r <= 1'b1; // RULE2
      else if (consume_w) pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r  <= 1'b0;
      dack_r <= 1'b0;
      lock_r <= 1'b0;
      breq_r <= 1'b0;
    end else begin
      irq_r  <= irq_nxt;
      dack_r <= issue_w && req_trig_w; // RULE14
      lock_r <= lock_nxt;
      breq_r <= arb_req;
    end
  end

  assign dat_o      = rdat_r;
  assign ack_o      = ack_r;
  assign mem_o      = mem_r;
  assign irq_o      = irq_r;
  assign dack_o     = dack_r;
  assign bus_lock_o = lock_r;
  assign bus_req_o  = breq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_len_done: assert property (item_done && idx_r == len_r |=> idx_r == 16'h0000) // RULE1
    else $error("index not cleared after last item");
  a_edge_pend: assert property (edge_w && enable_w && !pend_r ##1 pend_r // RULE2
    |-> $past(rise_w))
    else $error("edge mode pending set without rising edge");
  a_fill_read: assert property (st_r == S_READ && fill_w |-> idx_r == 16'h0000) // RULE3
    else $error("fill mode read source more than once");
  a_fill_hold: assert property (item_done && fill_w && idx_r != len_r |=> // RULE4
    st_r == S_WRITE && bus_lock_o)
    else $error("fill mode released the bus");
  a_block_gap: assert property (item_done && !idle_w && idx_r != len_r |=> st_r != S_GAP) // RULE6
    else $error("blocking mode inserted a wait");
  a_gap_one: assert property (st_r == S_GAP |=> st_r == S_ARB || st_r == S_IDLE) // RULE7
    else $error("wait longer than one cycle");
  a_auto_off: assert property (done_w && !restart_w && !wr_ctrl |=> !enable_w) // RULE10
    else $error("enable not cleared at completion");
  a_circ_keep: assert property (done_w && restart_w && !wr_ctrl |=> // RULE11
    enable_w && idx_r == 16'h0000 && st_r == S_ARB)
    else $error("wraparound did not restart");
  a_src_fixed: assert property (st_r == S_ARB && issue_w && !sinc_w && !fill_w |=> // RULE12
    mem_o.adr == $past(src_start))
    else $error("source moved without increment");
  a_irq_gate: assert property (irq_o |-> $past(irq_en_w) && $past(thr_r) == $past(idx_r)) // RULE15
    else $error("interrupt without enable or threshold match");
  a_off_idle: assert property (st_r == S_IDLE && !enable_w |=> st_r == S_IDLE) // RULE17
    else $error("disabled channel left idle");

endmodule // dma_channel_control

// ---- dv/mem_partner.sv ----
/*
  Memory partner on the far side of the channel's item port.
  Assumes the channel holds its request until it samples the ack.
*/
`timescale 1ns/10ps
module mem_partner (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire dma_channel_pkg::mem_req_t req_i,
  input  wire logic [1:0]                lat_i,
  output logic                           ack_o,
  output logic [31:0]                    rdata_o
);
  logic [1:0]  wait_r;
  logic [31:0] junk_r = 32'h5A5A5A5A;
  // ----
  // answer after lat_i wait cycles, one-cycle ack
  // ----
  always_ff @(posedge clk_i) begin
    junk_r <= junk_r + 32'h3;
    if (rst_i || !req_i.valid || ack_o) begin
      ack_o  <= 1'b0;
      wait_r <= 2'h0;
    end else if (wait_r >= lat_i) begin
      ack_o <= 1'b1;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
  // data is a function of the address; outside an ack it changes every cycle
  assign rdata_o = ack_o ? {~req_i.adr[15:0], req_i.adr[15:0]} : junk_r;
endmodule // mem_partner

// ---- dv/tb.sv ----
/*
  Self-checking bench for dma_channel_control with a memory partner.
  Assumes a 100 MHz clock, synchronous reset, one register access at a time.
*/
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] SL = dma_channel_pkg::SRC_LOW_IDX;
  localparam logic [31:0] LN = dma_channel_pkg::LEN_IDX;
  localparam logic [31:0] CT = dma_channel_pkg::CTRL_IDX;
  localparam logic [31:0] PG = dma_channel_pkg::PROGRESS_IDX;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, dreq = 1'b0;
  logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, rdata;
  logic [2:0] oreq = 3'h0;
  logic [2:0][2:0] oprio = '0;
  logic [1:0] lat = 2'h0;
  logic ack_o, mem_ack, dack_o, irq_o, bus_lock_o, breq;
  dma_channel_pkg::mem_req_t mem_o;
  logic [31:0] ra[$], wa[$], wd[$];
  int rt[$];
  int error_cnt = 0, n_checks = 0, nirq = 0, ndack = 0, nlock = 0, tick = 0;

  always #5 clk_i = ~clk_i;

  dma_channel_control dma_channel_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .sel_i(4'h3), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o), .ack_o(ack_o), .dreq_i(dreq), .dack_o(dack_o),
    .other_req_i(oreq), .other_prio_i(oprio), .bus_req_o(breq), .bus_lock_o(bus_lock_o),
    .mem_o(mem_o), .mem_ack_i(mem_ack), .mem_rdata_i(rdata), .irq_o(irq_o));
  mem_partner mem_partner_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_o), .lat_i(lat),
    .ack_o(mem_ack), .rdata_o(rdata));

  // ----
  // monitors and timeout
  // ----
  always @(posedge clk_i) begin
    if (mem_o.valid && mem_ack && mem_o.we) begin
      wa.push_back(mem_o.adr);
      wd.push_back(mem_o.wdata);
      nlock += !bus_lock_o;
    end else if (mem_o.valid && mem_ack) begin
      ra.push_back(mem_o.adr);
      rt.push_back(tick);
    end
    nirq += irq_o;
    ndack += dack_o;
    tick++;
    if (tick == 5000) begin
      error_cnt++;
      summarize;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wb(input logic [31:0] i, input logic w, input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= {i[29:0], 2'h0};
    we <= w;
    dat <= {16'h0, d};
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack", 1, n < 20);
  endtask

  task wr(input logic [31:0] i, input logic [15:0] d);
    logic [31:0] q;
    wb(i, 1'b1, d, q);
  endtask

  task rdc(input logic [31:0] i, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(i, 1'b0, 16'h0, q);
    chk(nm, e, q);
  endtask

  task setup(input logic [15:0] len, input logic [15:0] thr);
    wr(SL, 16'h1000);
    wr(SL + 32'h2, 16'h0002);
    wr(SL + 32'h4, 16'h2000);
    wr(SL + 32'h6, 16'h0003);
    wr(SL + 32'h8, thr);
    wr(LN, len);
    ra.delete();
    wa.delete();
    wd.delete();
    rt.delete();
    nirq = 0;
    ndack = 0;
    nlock = 0;
  endtask

  task wait_wr(input int n);
    int k;
    k = 0;
    while (wa.size() < n && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    repeat (4) @(posedge clk_i);
  endtask

  // ----
  // scenarios
  // ----
  task t_regs;
    rdc(LN, 32'h0, "len reset");
    rdc(CT, 32'h0, "ctrl reset");
    rdc(PG, 32'h0, "index reset");
    wr(CT, 16'hFFFE);
    rdc(CT, 32'h3FFE, "ctrl bits");
    wr(CT, 16'h0000);
    wr(PG, 16'h1234);
    rdc(PG, 32'h0, "index ro");
    rdc(SL + 32'h30, 32'h0, "unmapped");
  endtask

  task t_copy;
    logic [31:0] a;
    setup(16'h2, 16'h1);
    wr(CT, 16'h036D);
    wait_wr(3);
    chk("writes", 3, wa.size());
    chk("reads", 3, ra.size());
    for (int i = 0; i < 3; i++) begin
      a = 32'h21000 + 4 * i;
      chk("src adr", a, ra[i]);
      chk("dst adr", 32'h32000 + 4 * i, wa[i]);
      chk("data", {~a[15:0], a[15:0]}, wd[i]);
    end
    chk("irq", 1, nirq);
    chk("b2b spacing", 5, rt[1] - rt[0]);
    chk("locked", 0, nlock);
    rdc(CT, 32'h036C, "auto off");
    rdc(PG, 32'h0, "index end");
  endtask

  task t_fill;
    setup(16'h3, 16'h0);
    lat <= 2'h2;
    // fill always paired with destination increment, never request mode
    wr(CT, 16'h1023);
    wait_wr(4);
    chk("fill reads", 1, ra.size());
    for (int i = 0; i < 4; i++) begin
      chk("fill adr", 32'h32000 + 2 * i, wa[i]);
      chk("fill data", 32'hEFFF1000, wd[i]);
    end
    chk("unlocked", 0, nlock);
    chk("irq off", 0, nirq);
  endtask

  task t_req;
    setup(16'h1, 16'h0);
    lat <= 2'h0;
    wr(CT, 16'h2031);
    repeat (30) @(posedge clk_i);
    chk("no req", 0, wa.size());
    chk("no bus req", 0, breq);
    dreq <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk("one edge", 1, wa.size());
    dreq <= 1'b0;
    repeat (5) @(posedge clk_i);
    dreq <= 1'b1;
    wait_wr(2);
    chk("src fixed", 32'h21000, ra[1]);
    chk("dst byte", 32'h32001, wa[1]);
    chk("dack", 2, ndack);
    rdc(CT, 32'h2030, "req off");
    dreq <= 1'b0;
  endtask

  task t_arb;
    setup(16'h0, 16'h0);
    oreq <= 3'h1;
    oprio[0] <= 3'h3;
    wr(CT, 16'h0305);
    repeat (40) @(posedge clk_i);
    chk("tie", 0, ra.size());
    chk("bus req", 1, breq);
    oprio[0] <= 3'h2;
    wait_wr(1);
    chk("prio", 1, wa.size());
    oreq <= 3'h0;
  endtask

  task t_gap;
    setup(16'h1, 16'h0);
    wr(CT, 16'h0865);
    wait_wr(2);
    chk("idle spacing", 6, rt[1] - rt[0]);
    chk("idle unlocked", 2, nlock);
  endtask

  task t_circ;
    setup(16'h1, 16'h0);
    wr(CT, 16'h2030);
    dreq <= 1'b1;
    repeat (10) @(posedge clk_i);
    wr(CT, 16'h20B1);
    repeat (20) @(posedge clk_i);
    chk("off edge", 0, wa.size());
    for (int i = 0; i < 4; i++) begin
      dreq <= 1'b0;
      repeat (5) @(posedge clk_i);
      dreq <= 1'b1;
      repeat (20) @(posedge clk_i);
    end
    chk("circ items", 4, wa.size());
    chk("circ restart", 32'h32000, wa[2]);
    rdc(CT, 32'h20B1, "circ on");
    rdc(PG, 32'h0, "circ index");
    wr(CT, 16'h0000);
    dreq <= 1'b0;
  endtask

  task summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_copy;
    t_fill;
    t_req;
    t_arb;
    t_gap;
    t_circ;
    summarize;
  end
endmodule // tb
